// File: inc/usart_lin_pkg.sv
// register map, field positions, reset values and types of the serial unit
// assumes one 20 MHz clock and a plain strobe register port
package usart_lin_pkg;
	// register port request, one per cycle
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} regReq_t;
	// one byte beat of the dma streams
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} byteBeat_t;
	// operating modes of the unit
	typedef enum logic [1:0] {
		MODE_NORMAL     = 2'h0,
		MODE_HANDSHAKE  = 2'h1,
		MODE_ISO_T1     = 2'h2,
		MODE_LIN_MASTER = 2'h3
	} serMode_t;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_MODE    = 8'h04;
	localparam logic [7:0] OFS_BUSMODE = 8'h08;
	localparam logic [7:0] OFS_IDENT   = 8'h0c;
	localparam logic [7:0] OFS_STATUS  = 8'h10;
	localparam logic [7:0] OFS_MASK    = 8'h14;
	localparam logic [7:0] OFS_RXDATA  = 8'h18;
	localparam logic [7:0] OFS_BAUD    = 8'h1c;
	// command bits of the control register
	localparam int CTRL_RX_RESET = 0;
	localparam int CTRL_RTS_HIGH = 1;
	localparam int CTRL_RTS_LOW  = 2;
	// status and mask bit positions
	localparam int ST_IDENT  = 0;
	localparam int ST_RXBYTE = 1;
	localparam int ST_TXDONE = 2;
	localparam int ST_BREAK  = 3;
	localparam int ST_W      = 4;
	// reset values
	localparam logic [15:0] BAUD_RST = 16'h000a;
	localparam logic [ST_W-1:0] MASK_RST = 4'h0;
	// framing counts, in oversample ticks and bits
	localparam int OVERSAMPLE  = 16;
	localparam int BREAK_BITS  = 13;
	localparam int FRAME_BITS  = 10;
	localparam int BREAK_TICKS = BREAK_BITS * OVERSAMPLE;
	localparam int HALF_BIT    = OVERSAMPLE / 2;
	localparam logic [7:0] SYNC_BYTE = 8'h55;
endpackage : usart_lin_pkg

// File: src/baud_tick.sv
// oversample tick divider: one-cycle enable every divisor+1 clocks
// assumes divisor is held steady by software while the link is in use
`timescale 1ns/1ps
module baud_tick #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst_n,
	// divider setting
	input  wire logic [W-1:0] divisor,
	// tick out
	output logic              tick
);
	logic [W-1:0] cnt_r;  // running count
	logic         tick_r; // registered pulse
	wire          wrap = (cnt_r >= divisor);
	// count up and wrap
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= wrap ? '0 : W'(cnt_r + 1'b1);
			tick_r <= wrap;
		end
	end
	assign tick = tick_r;
endmodule : baud_tick

// File: src/rx_sync.sv
// three-stage pin synchroniser, level follows once stages two and three agree
// assumes the pin idles high
`timescale 1ns/1ps
module rx_sync (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// raw pin and clean level
	input  wire logic pinIn,
	output logic      level
);
	logic s1_r; // metastable stage, read only by s2_r
	logic s2_r; // second stage
	logic s3_r; // third stage
	logic lv_r; // accepted level
	// shift the pin through and accept agreed values
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
			lv_r <= 1'b1;
		end else begin
			s1_r <= pinIn;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) lv_r <= s3_r;
		end
	end
	assign level = lv_r;
endmodule : rx_sync

// File: src/usart_lin_handshake_dma.sv
// serial unit with lin master header, dma streams, rts forcing, t1 rx lock
// assumes a dma engine on dmaTx/dmaRx and software on the strobe register port
// Contract
// - ident write starts header once dma ready
// - header ident comes from register, not dma
// - ident interrupt only on received header
// - lin with select one never starts dma
// - handshake mode leaves rts low
// - force-high command drives rts high
// - force-low command drives rts low, unless force-high is written with it
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module usart_lin_handshake_dma #(
	parameter int DIV_W = 16
) (
	// clock and reset
	input  wire logic                   clock,
	input  wire logic                   rst_n,
	// register port
	input  wire usart_lin_pkg::regReq_t regReq,
	output logic [31:0]                 rdata,
	// dma streams
	input  wire usart_lin_pkg::byteBeat_t dmaTx,
	output logic                        dmaTxReady,
	output usart_lin_pkg::byteBeat_t    dmaRx,
	// serial pins
	input  wire logic                   rxdPin,
	output logic                        txd,
	output logic                        rts,
	// interrupt
	output logic                        irq
);
	import usart_lin_pkg::*;
	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001, TX_BREAK = 4'b0010, TX_DELIM = 4'b0100, TX_SHIFT = 4'b1000
	} txState_t;
	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000
	} rxState_t;
	// configuration and status registers
	serMode_t         mode_r;     // operating mode
	logic             hdrSel_r;   // dma_header_mode_sel
	logic [7:0]       identReg_r; // frame_ident to send
	logic [7:0]       identRx_r;  // last received ident
	logic [DIV_W-1:0] baud_r;     // tick divisor
	logic [ST_W-1:0]  status_r;   // sticky events
	logic [ST_W-1:0]  mask_r;     // interrupt mask
	logic [31:0]      rdata_r;    // read data
	logic             irq_r;      // interrupt level
	logic             rts_r;      // rts pin
	// transmit state
	txState_t  txState_r, txStateNxt;
	logic [7:0] sub_r, subNxt;      // tick counter in bit or break
	logic [9:0] shift_r, shiftNxt;  // frame shifter, lsb out first
	logic [3:0] bit_r, bitNxt;      // bit index
	logic [1:0] hdrLeft_r, hdrLeftNxt; // header bytes still to send
	logic       identArm_r, identArmNxt; // header armed by ident write
	logic       linFrame_r, linFrameNxt; // lin frame open for dma data
	logic       txd_r, ready_r;
	logic       txDoneEv;
	// receive state
	rxState_t   rxState_r, rxStateNxt;
	logic [7:0] rsub_r, rsubNxt;
	logic [7:0] rshift_r, rshiftNxt;
	logic [3:0] rbit_r, rbitNxt;
	logic       rxPrev_r;        // previous clean level
	logic       rxLock_r;        // t1 reception blocked
	logic [1:0] hdrRx_r;         // 0 none, 1 break seen, 2 sync seen
	logic [7:0] rxData_r;        // last received byte
	byteBeat_t  dmaRx_r;
	logic       frameEv;         // stop bit sampled
	// helpers
	logic tick;
	logic rxIn;
	baud_tick #(.W(DIV_W)) u_tick (
		.clock   (clock),
		.rst_n   (rst_n),
		.divisor (baud_r),
		.tick    (tick)
	);
	rx_sync u_sync (
		.clock (clock),
		.rst_n (rst_n),
		.pinIn (rxdPin),
		.level (rxIn)
	);
	// register decode
	wire wrCtrl    = regReq.wr && (regReq.addr == OFS_CTRL);
	wire wrMode    = regReq.wr && (regReq.addr == OFS_MODE);
	wire wrBusMode = regReq.wr && (regReq.addr == OFS_BUSMODE);
	wire wrIdent   = regReq.wr && (regReq.addr == OFS_IDENT);
	wire wrStatus  = regReq.wr && (regReq.addr == OFS_STATUS);
	wire wrMask    = regReq.wr && (regReq.addr == OFS_MASK);
	wire wrBaud    = regReq.wr && (regReq.addr == OFS_BAUD);
	// commands act only on a written one
	wire rxResetCmd = wrCtrl && regReq.wdata[CTRL_RX_RESET];
	wire rtsHighCmd = wrCtrl && regReq.wdata[CTRL_RTS_HIGH];
	wire rtsLowCmd  = wrCtrl && regReq.wdata[CTRL_RTS_LOW];
	wire linMaster  = (mode_r == MODE_LIN_MASTER);
	wire isoT1      = (mode_r == MODE_ISO_T1);
	// read mux, control register reads zero
	wire [31:0] rdMux =
		(regReq.addr == OFS_MODE)    ? {30'h0, mode_r} :
		(regReq.addr == OFS_BUSMODE) ? {31'h0, hdrSel_r} :
		(regReq.addr == OFS_IDENT)   ? {16'h0, identRx_r, identReg_r} :
		(regReq.addr == OFS_STATUS)  ? {28'h0, status_r} :
		(regReq.addr == OFS_MASK)    ? {28'h0, mask_r} :
		(regReq.addr == OFS_RXDATA)  ? {24'h0, rxData_r} :
		(regReq.addr == OFS_BAUD)    ? {{(32 - DIV_W){1'b0}}, baud_r} : 32'h0;
	// transmit decode
	wire txIdle  = (txState_r == TX_IDLE);
	wire take    = ready_r && dmaTx.valid;
	// header waits until the dma transfer offers its first byte
	wire hdrStart = txIdle && identArm_r && dmaTx.valid;
	wire [7:0] txLimit = (txState_r == TX_BREAK) ? 8'(BREAK_TICKS - 1) : 8'(OVERSAMPLE - 1);
	wire txStep  = tick && (sub_r == txLimit);
	// dma data flows freely outside lin; in lin only after header, select zero
	wire dmaOkNxt = linMaster ? (!hdrSel_r && linFrameNxt) : 1'b1;
	wire readyNxt = (txStateNxt == TX_IDLE) && (hdrLeftNxt == 2'd0) && !identArmNxt && dmaOkNxt;
	wire txdNxt   = (txStateNxt == TX_BREAK) ? 1'b0 :
		(txStateNxt == TX_SHIFT) ? shiftNxt[0] : 1'b1;
	// transmit sequencer
	always_comb begin
		txStateNxt  = txState_r;
		subNxt      = sub_r;
		shiftNxt    = shift_r;
		bitNxt      = bit_r;
		hdrLeftNxt  = hdrLeft_r;
		identArmNxt = identArm_r;
		linFrameNxt = linFrame_r;
		txDoneEv    = 1'b0;
		case (txState_r)
			TX_IDLE: begin
				if (hdrStart) begin
					txStateNxt  = TX_BREAK;
					subNxt      = 8'h00;
					identArmNxt = 1'b0;
					linFrameNxt = 1'b1;
					hdrLeftNxt  = 2'd2;
				end else if (hdrLeft_r != 2'd0) begin
					// sync first, then the register ident, never a dma byte
					shiftNxt   = {1'b1, (hdrLeft_r == 2'd2) ? SYNC_BYTE : identReg_r, 1'b0};
					hdrLeftNxt = 2'(hdrLeft_r - 1'b1);
					txStateNxt = TX_SHIFT;
					subNxt     = 8'h00;
					bitNxt     = 4'h0;
				end else if (take) begin
					shiftNxt   = {1'b1, dmaTx.data, 1'b0};
					txStateNxt = TX_SHIFT;
					subNxt     = 8'h00;
					bitNxt     = 4'h0;
				end else if (!dmaTx.valid) begin
					// dma drained: the lin frame is over
					linFrameNxt = 1'b0;
				end
				// arm on ident write, lin master with select zero only
				if (wrIdent && linMaster && !hdrSel_r) identArmNxt = 1'b1;
			end
			TX_BREAK, TX_DELIM: begin
				if (tick) subNxt = 8'(sub_r + 1'b1);
				if (txStep) begin
					subNxt     = 8'h00;
					txStateNxt = (txState_r == TX_BREAK) ? TX_DELIM : TX_IDLE;
				end
			end
			TX_SHIFT: begin
				if (tick) subNxt = 8'(sub_r + 1'b1);
				if (txStep) begin
					subNxt   = 8'h00;
					shiftNxt = {1'b1, shift_r[9:1]};
					bitNxt   = 4'(bit_r + 1'b1);
					if (bit_r == 4'(FRAME_BITS - 1)) begin
						txStateNxt = TX_IDLE;
						bitNxt     = 4'h0;
						txDoneEv   = 1'b1;
					end
				end
			end
			default: txStateNxt = TX_IDLE;
		endcase
		if (wrIdent && !txIdle && linMaster && !hdrSel_r) identArmNxt = 1'b1;
	end
	// transmit registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			txState_r  <= TX_IDLE;
			sub_r      <= 8'h00;
			shift_r    <= 10'h3ff;
			bit_r      <= 4'h0;
			hdrLeft_r  <= 2'd0;
			identArm_r <= 1'b0;
			linFrame_r <= 1'b0;
			txd_r      <= 1'b1;
			ready_r    <= 1'b0;
		end else begin
			txState_r  <= txStateNxt;
			sub_r      <= subNxt;
			shift_r    <= shiftNxt;
			bit_r      <= bitNxt;
			hdrLeft_r  <= hdrLeftNxt;
			identArm_r <= identArmNxt;
			linFrame_r <= linFrameNxt;
			txd_r      <= txdNxt;
			ready_r    <= readyNxt;
		end
	end
	// receive decode
	wire rxFall  = rxPrev_r && !rxIn;
	wire rxHalf  = tick && (rsub_r == 8'(HALF_BIT - 1));
	wire rxFull  = tick && (rsub_r == 8'(OVERSAMPLE - 1));
	wire breakEv = frameEv && (rshift_r == 8'h00) && !rxIn;
	wire byteEv  = frameEv && !breakEv;
	// ident event comes only from a received header
	wire identEv = byteEv && linMaster && (hdrRx_r == 2'd2);
	// receive sequencer
	always_comb begin
		rxStateNxt = rxState_r;
		rsubNxt    = rsub_r;
		rshiftNxt  = rshift_r;
		rbitNxt    = rbit_r;
		frameEv    = 1'b0;
		case (rxState_r)
			RX_IDLE: begin
				if (rxFall && !rxLock_r) begin
					rxStateNxt = RX_START;
					rsubNxt    = 8'h00;
				end
			end
			RX_START: begin
				if (tick) rsubNxt = 8'(rsub_r + 1'b1);
				if (rxHalf) begin
					rsubNxt    = 8'h00;
					rbitNxt    = 4'h0;
					rxStateNxt = rxIn ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (tick) rsubNxt = 8'(rsub_r + 1'b1);
				if (rxFull) begin
					rsubNxt   = 8'h00;
					rshiftNxt = {rxIn, rshift_r[7:1]};
					rbitNxt   = 4'(rbit_r + 1'b1);
					if (rbit_r == 4'h7) rxStateNxt = RX_STOP;
				end
			end
			RX_STOP: begin
				if (tick) rsubNxt = 8'(rsub_r + 1'b1);
				if (rxFull) begin
					frameEv    = 1'b1;
					rxStateNxt = RX_IDLE;
				end
			end
			default: rxStateNxt = RX_IDLE;
		endcase
	end
	// receive registers; soft reset clears the receiver and its lock
	always_ff @(posedge clock) begin
		if (!rst_n || rxResetCmd) begin
			rxState_r <= RX_IDLE;
			rsub_r    <= 8'h00;
			rshift_r  <= 8'h00;
			rbit_r    <= 4'h0;
			rxLock_r  <= 1'b0;
			hdrRx_r   <= 2'd0;
		end else begin
			rxState_r <= rxStateNxt;
			rsub_r    <= rsubNxt;
			rshift_r  <= rshiftNxt;
			rbit_r    <= rbitNxt;
			// t1 reception dies after any transmitted byte
			if (isoT1 && txDoneEv) rxLock_r <= 1'b1;
			// lin header tracker: break, sync, ident
			if (breakEv) hdrRx_r <= 2'd1;
			else if (byteEv) hdrRx_r <= (hdrRx_r == 2'd1 && rshift_r == SYNC_BYTE) ? 2'd2 : 2'd0;
		end
	end
	// received data and dma beat
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rxData_r  <= 8'h00;
			identRx_r <= 8'h00;
			dmaRx_r   <= '0;
			rxPrev_r  <= 1'b1;
		end else begin
			rxPrev_r      <= rxIn;
			dmaRx_r.valid <= byteEv;
			if (byteEv) rxData_r <= rshift_r;
			if (byteEv) dmaRx_r.data <= rshift_r;
			if (identEv) identRx_r <= rshift_r;
		end
	end

	// event vector; a new event beats a same-cycle clear
	wire [ST_W-1:0] evVec = {breakEv, txDoneEv, byteEv, identEv};
	wire [ST_W-1:0] clrVec = wrStatus ? regReq.wdata[ST_W-1:0] : '0;

	// configuration, status, interrupt and read data
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mode_r     <= MODE_NORMAL;
			hdrSel_r   <= 1'b0;
			identReg_r <= 8'h00;
			baud_r     <= DIV_W'(BAUD_RST);
			status_r   <= '0;
			mask_r     <= MASK_RST;
			rdata_r    <= 32'h0;
			irq_r      <= 1'b0;
		end else begin
			if (wrMode) mode_r <= serMode_t'(regReq.wdata[1:0]);
			if (wrBusMode) hdrSel_r <= regReq.wdata[0];
			if (wrIdent) identReg_r <= regReq.wdata[7:0];
			if (wrBaud) baud_r <= regReq.wdata[DIV_W-1:0];
			if (wrMask) mask_r <= regReq.wdata[ST_W-1:0];
			status_r <= (status_r & ~clrVec) | evVec;
			rdata_r  <= regReq.rd ? rdMux : 32'h0;
			irq_r    <= |(status_r & mask_r);
		end
	end

	// rts: only the force commands move it; handshake mode never raises it
	always_ff @(posedge clock) begin
		if (!rst_n) rts_r <= 1'b0;
		else if (rtsHighCmd) rts_r <= 1'b1;
		else if (rtsLowCmd) rts_r <= 1'b0;
	end

	// outputs
	assign rdata      = rdata_r;
	assign dmaTxReady = ready_r;
	assign dmaRx      = dmaRx_r;
	assign txd        = txd_r;
	assign rts        = rts_r;
	assign irq        = irq_r;

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	hdr_wait_dma_a: assert property (hdrStart |=> txState_r == TX_BREAK ##1 txd_r == 1'b0)
		else $error("header did not start on dma ready");
	ident_from_reg_a: assert property ((txIdle && hdrLeft_r == 2'd1)
		|=> shift_r[8:1] == $past(identReg_r) && !$past(take))
		else $error("header ident not taken from register");
	ident_irq_rx_a: assert property ($rose(status_r[ST_IDENT]) |-> $past(rxState_r) == RX_STOP)
		else $error("ident flag set without received header");
	no_dma_sel1_a: assert property ((linMaster && hdrSel_r && !wrMode && !wrBusMode)
		|=> !ready_r)
		else $error("dma offered in lin with select one");
	rts_hs_low_a: assert property ((mode_r == MODE_HANDSHAKE && !rtsHighCmd && !rts_r)
		|=> !rts_r) else $error("handshake mode raised rts");
	rts_high_a: assert property (rtsHighCmd |=> rts_r ##1 (rts_r || $past(rtsLowCmd)))
		else $error("force high did not raise rts");
	rts_low_a: assert property ((rtsLowCmd && !rtsHighCmd) |=> !rts_r)
		else $error("force low did not lower rts");
	ctrl_read_zero_a: assert property ((regReq.rd && regReq.addr == OFS_CTRL) |=> rdata_r == 32'h0)
		else $error("control register read not zero");
	break_len_a: assert property ($rose(txState_r == TX_BREAK) |-> ##1 !txd_r [*8])
		else $error("break too short");
	hdr_cov_c: cover property (hdrStart ##[1:1000] txState_r == TX_SHIFT);
	ident_cov_c: cover property (identEv);
	rts_cov_c: cover property (rtsHighCmd ##[1:50] rtsLowCmd);
	rxbyte_cov_c: cover property (byteEv && !linMaster);
endmodule : usart_lin_handshake_dma

// File: verif/serial_peer.sv
// serial peer model: drives frames and breaks onto the rx pin, decodes the tx pin
// assumes the unit runs at baud divisor 0, so one bit lasts 16 clocks
`timescale 1ns/1ps
module serial_peer #(
	parameter int BIT_CLK = 16
) (
	// clock
	input  wire logic clock,
	// serial lines
	input  wire logic txdIn,
	output logic      rxdOut
);
	logic [8:0] got[$];  // decoded frames, 9'h100 marks a break
	logic [8:0] frame;   // frame being decoded

	// line idles high, as a pulled-up wire would
	initial rxdOut = 1'b1;

	// hold one level for a number of bit times, started just after an edge
	task automatic hold(input logic lvl, input int bits);
		rxdOut <= lvl;
		repeat (bits * BIT_CLK) @(posedge clock);
	endtask : hold

	// one frame, lsb first, with its stop bit and one idle bit after it
	task automatic sendFrame(input logic [7:0] v);
		hold(1'b0, 1);
		for (int i = 0; i < 8; i++) hold(v[i], 1);
		hold(1'b1, 2);
	endtask : sendFrame

	// thirteen low bits, then a high delimiter
	task automatic sendBreak();
		hold(1'b0, 13);
		hold(1'b1, 2);
	endtask : sendBreak

	// decoder: sample mid-bit after each falling edge
	initial begin
		forever begin
			@(negedge txdIn);
			repeat (BIT_CLK / 2) @(posedge clock);
			for (int i = 0; i < 9; i++) begin
				repeat (BIT_CLK) @(posedge clock);
				frame[i] = txdIn;
			end
			// low stop level means a break
			if (frame[8] === 1'b1) begin
				got.push_back({1'b0, frame[7:0]});
			end else begin
				got.push_back(9'h100);
				wait (txdIn === 1'b1);
			end
		end
	end
endmodule : serial_peer

// File: verif/testbench.sv
// self-checking bench: registers, rts forcing, lin header send and receive, t1 recovery
// assumes the peer model on the serial pins and one 20 MHz clock
`timescale 1ns/1ps
module testbench;
	import usart_lin_pkg::*;
	logic        clock;        // 20 MHz clock
	logic        rst_n;        // synchronous reset
	regReq_t     regReq;       // register request
	logic [31:0] rdata;        // read data
	byteBeat_t   dmaTx;        // dma transmit beat
	logic        dmaTxReady;   // transmit byte taken
	byteBeat_t   dmaRx;        // dma receive beat
	logic        rxd;          // peer to unit
	logic        txd;          // unit to peer
	logic        rts;          // request to send
	logic        irq;          // interrupt
	int          n_fail;       // mismatches
	int          check_count;  // comparisons
	int          rxCount = 0;  // receive beats seen
	logic [7:0]  rxLast;       // last received byte
	logic [31:0] d;            // last read word

	usart_lin_handshake_dma dut_u (.clock(clock), .rst_n(rst_n), .regReq(regReq),
		.rdata(rdata), .dmaTx(dmaTx), .dmaTxReady(dmaTxReady), .dmaRx(dmaRx),
		.rxdPin(rxd), .txd(txd), .rts(rts), .irq(irq));
	serial_peer peer_u (.clock(clock), .txdIn(txd), .rxdOut(rxd));

	// free-running clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// count receive beats
	always @(posedge clock) begin
		if (dmaRx.valid === 1'b1) begin
			rxCount++;
			rxLast = dmaRx.data;
		end
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results

	// a limit ran out
	task automatic fail(input string what);
		n_fail++;
		$display("mismatch %s expected done seen timeout", what);
		results();
	endtask : fail

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc

	// offer one dma byte, held by the caller until taken
	task automatic offer(input logic [7:0] v);
		dmaTx <= '{valid: 1'b1, data: v};
	endtask : offer

	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		regReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		regReq.wr <= 1'b0;
	endtask : wr

	// read, data taken in the cycle after the strobe, masked compare
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string what);
		@(posedge clock);
		regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		regReq.rd <= 1'b0;
		@(posedge clock);
		d = rdata;
		check(what, e, d & m);
	endtask : rc

	// control command, then rts level two cycles on
	task automatic rtsCmd(input logic [31:0] v, input logic e);
		wr(OFS_CTRL, v);
		cyc(2);
		check("rts", {31'h0, e}, {31'h0, rts});
	endtask : rtsCmd

	task automatic waitGot(input int n);
		for (int i = 0; i < 4000 && peer_u.got.size() < n; i++) @(posedge clock);
		if (peer_u.got.size() < n) fail("tx frames");
	endtask : waitGot

	task automatic waitRx(input int n);
		for (int i = 0; i < 4000 && rxCount < n; i++) @(posedge clock);
		if (rxCount < n) fail("rx beats");
	endtask : waitRx

	// hold valid until taken, then drop it
	task automatic waitTake();
		for (int i = 0; i < 4000; i++) begin
			@(posedge clock);
			if (dmaTxReady === 1'b1) begin
				dmaTx.valid <= 1'b0;
				return;
			end
		end
		fail("dma take");
	endtask : waitTake

	task automatic t_reset();
		check("txd idle", 32'h1, {31'h0, txd});
		check("rts reset", 32'h0, {31'h0, rts});
		check("irq reset", 32'h0, {31'h0, irq});
		rc(OFS_MASK, 32'hf, {28'h0, MASK_RST}, "mask reset");
		rc(OFS_BAUD, 32'hffff, {16'h0, BAUD_RST}, "baud reset");
		wr(OFS_CTRL, 32'h7);
		rc(OFS_CTRL, 32'hffff_ffff, 32'h0, "ctrl reads zero");
		wr(8'h20, 32'hffff_ffff);
		rc(8'h20, 32'hffff_ffff, 32'h0, "unmapped");
		wr(OFS_BAUD, 32'h0);
		rc(OFS_BAUD, 32'hffff, 32'h0, "baud");
	endtask : t_reset

	task automatic t_rts();
		wr(OFS_MODE, 32'h0);
		peer_u.sendFrame(8'h5a);
		waitRx(1);
		check("rx data", 32'h5a, {24'h0, rxLast});
		rtsCmd(32'h4, 1'b0);
		rtsCmd(32'h2, 1'b1);
		rtsCmd(32'h0, 1'b1);
		rtsCmd(32'h4, 1'b0);
		wr(OFS_MODE, 32'h1);
		peer_u.sendFrame(8'hc3);
		waitRx(2);
		check("rts handshake", 32'h0, {31'h0, rts});
		rtsCmd(32'h6, 1'b1);
		rtsCmd(32'h4, 1'b0);
	endtask : t_rts

	task automatic t_linTx();
		wr(OFS_MODE, 32'h3);
		wr(OFS_BUSMODE, 32'h0);
		peer_u.got.delete();
		offer(8'ha5);
		wr(OFS_IDENT, 32'h3a);
		waitTake();
		check("frames at take", 32'h3, peer_u.got.size());
		waitGot(4);
		check("break", 32'h100, {23'h0, peer_u.got[0]});
		check("sync", {24'h0, SYNC_BYTE}, {23'h0, peer_u.got[1]});
		check("ident", 32'h3a, {23'h0, peer_u.got[2]});
		check("first data", 32'ha5, {23'h0, peer_u.got[3]});
		rc(OFS_STATUS, 32'h1, 32'h0, "ident flag on send");
	endtask : t_linTx

	task automatic t_linSel1();
		logic bad;
		bad = 1'b0;
		wr(OFS_BUSMODE, 32'h1);
		offer(8'h11);
		wr(OFS_IDENT, 32'h22);
		for (int i = 0; i < 600; i++) begin
			@(posedge clock);
			if (dmaTxReady !== 1'b0 || txd !== 1'b1) bad = 1'b1;
		end
		check("select one idle", 32'h0, {31'h0, bad});
		dmaTx.valid <= 1'b0;
	endtask : t_linSel1

	task automatic t_linRx();
		wr(OFS_CTRL, 32'h1);
		wr(OFS_BUSMODE, 32'h0);
		peer_u.sendBreak();
		peer_u.sendFrame(SYNC_BYTE);
		peer_u.sendFrame(8'h2c);
		cyc(4);
		rc(OFS_STATUS, 32'h9, 32'h9, "ident and break flags");
		rc(OFS_IDENT, 32'hff00, 32'h2c00, "received ident");
		check("irq masked", 32'h0, {31'h0, irq});
		wr(OFS_MASK, 32'h1);
		cyc(3);
		check("irq", 32'h1, {31'h0, irq});
		wr(OFS_STATUS, 32'h1);
		cyc(3);
		check("irq cleared", 32'h0, {31'h0, irq});
		rc(OFS_STATUS, 32'h1, 32'h0, "ident flag cleared");
		wr(OFS_MASK, 32'h0);
	endtask : t_linRx

	task automatic t_isoT1();
		int n0;
		wr(OFS_MODE, 32'h2);
		peer_u.got.delete();
		offer(8'h96);
		waitTake();
		waitGot(1);
		check("t1 tx", 32'h96, {23'h0, peer_u.got[0]});
		cyc(32);
		n0 = rxCount;
		peer_u.sendFrame(8'h3c);
		cyc(4);
		check("rx locked", n0, rxCount);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_MODE, 32'h2);
		wr(OFS_CTRL, 32'h4);
		peer_u.sendFrame(8'he1);
		waitRx(n0 + 1);
		check("rx recovered", 32'he1, {24'h0, rxLast});
	endtask : t_isoT1

	// reset for 8 cycles, then each scenario in turn
	initial begin
		n_fail = 0;
		check_count = 0;
		rst_n = 1'b0;
		regReq = '0;
		dmaTx = '0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		t_reset();
		t_rts();
		t_linTx();
		t_linSel1();
		t_linRx();
		t_isoT1();
		results();
	end
endmodule : testbench
